// ==== hdl/mqaf_pkg.sv ====
// Purpose: Shared constants and types of the multi-queue almost flag logic
// Assumes: One clock, registers on a plain strobe port with 32-bit data
// Notes:   Status flags are active low, as on the device pins
package mqaf_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_QUEUES = 32;
	localparam int QADDR_W    = 5;
	localparam int BUS_BITS   = 8;
	localparam int CNT_W      = 18;
	localparam int OFS_W      = 16;

	typedef logic [CNT_W-1:0] mqaf_cnt_t;
	typedef logic [OFS_W-1:0] mqaf_ofs_t;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_AE_OFS = 8'h04;
	localparam logic [7:0] REG_AF_OFS = 8'h08;
	localparam logic [7:0] REG_DEPTH  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_WCOUNT = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_IN_WIDE  = 0;
	localparam int CTRL_OUT_WIDE = 1;
	localparam int CTRL_NQ_LSB   = 8;
	localparam int CTRL_NQ_W     = 6;
	localparam int STAT_QUAD_LSB = 0;
	localparam int STAT_OWN      = 2;
	localparam int STAT_FM       = 3;
	localparam int STAT_DF       = 4;
	localparam int STAT_READY    = 5;

	// ==========================================================
	// Reset values and defaults
	localparam logic [CTRL_NQ_W-1:0] CTRL_NQ_RST = 6'h20;
	localparam logic [1:0]           CTRL_BW_RST = 2'h0;
	localparam mqaf_ofs_t            DEPTH_RST   = 16'h0800;
	localparam mqaf_ofs_t            OFS_SMALL   = 16'h0008;
	localparam mqaf_ofs_t            OFS_LARGE   = 16'h0080;
	localparam logic [CTRL_NQ_W-1:0] SMALL_NQ    = 6'h08;

	// ==========================================================
	// Timing counts in clock cycles
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [2:0] {
		BUS_SMALL  = 3'h1,
		BUS_DIRECT = 3'h2,
		BUS_POLLED = 3'h4
	} mqaf_bus_e;

endpackage : mqaf_pkg

// ==== hdl/mqaf_qbank.sv ====
// Purpose: Per-queue fill counters, counted in 9-bit units
// Assumes: Controller never reads past empty nor writes past full
// Notes:   Counts and shared bits come straight from registers
module mqaf_qbank #(
	parameter int NQ = 32,
	parameter int QW = 5,
	parameter int CW = 18
) (
	input  wire logic                  mclk,
	input  wire logic                  arst_n,
	input  wire logic                  wr_en,
	input  wire logic [QW-1:0]         wr_q,
	input  wire logic [1:0]            wr_wt,
	input  wire logic                  rd_en,
	input  wire logic [QW-1:0]         rd_q,
	input  wire logic [1:0]            rd_wt,
	output logic      [NQ-1:0][CW-1:0] count_q,
	output logic      [NQ-1:0]         shared_q
);

	// ==========================================================
	// Counter per queue
	for (genvar g = 0; g < NQ; g++) begin : g_q
		wire logic          hit_w = wr_en && (wr_q == QW'(g));
		// A read that would underflow is dropped rather than wrapping
		wire logic          hit_r = rd_en && (rd_q == QW'(g)) && (count_q[g] >= CW'(rd_wt));
		wire logic [CW-1:0] add_w = hit_w ? CW'(wr_wt) : '0;
		wire logic [CW-1:0] sub_w = hit_r ? CW'(rd_wt) : '0;

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				count_q[g]  <= '0;
				shared_q[g] <= 1'b0;
			end else begin
				count_q[g] <= count_q[g] + add_w - sub_w;
				// Remember whether the read port held this queue at its first word
				if (hit_w && count_q[g] == '0) begin
					shared_q[g] <= (rd_q == QW'(g));
				end
			end
		end
	end

endmodule : mqaf_qbank

// ==== hdl/mqaf_flagpipe.sv ====
// Purpose: Asymmetric flag delay, slow to assert and fast to release
// Assumes: raw is high while the flag is inactive
// Notes:   nxt is combinational; callers register it once more
module mqaf_flagpipe #(
	parameter int   N   = 32,
	parameter logic RST = 1'b1
) (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic [N-1:0] raw,
	output logic      [N-1:0] nxt
);

	logic [N-1:0] prev_q;

	// ==========================================================
	// Low needs two samples, high needs one
	assign nxt = raw | prev_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= {N{RST}};
		end else begin
			prev_q <= raw;
		end
	end

endmodule : mqaf_flagpipe

// ==== hdl/mqaf_top.sv ====
// Purpose: Almost-empty, almost-full and full flag logic for 32 queues
// Assumes: Read and write ports share mclk; controller logic is on mclk
// Notes:   Skew margins between ports are always met on one clock
//
// How it works
// (R1) Equal widths: empty release after n+2 or n+1
// (R2) Wide in, narrow out: release after n+1
// (R3) Narrow in, wide out: release after doubled count
// (R4) Empty offset defaults 8 or 128 by strap
// (R5) Active empty flag: set two, release one
// (R6) Empty bus bit: set two, release one
// (R7) Read queue switch may add one cycle
// (R8) Equal widths: full-side after D+1-m or D-m
// (R9) Wide in, narrow out: almost full after D-m
// (R10) Narrow in, wide out: after doubled D+1-m
// (R11) Full offset defaults 8 or 128 by strap
// (R12) Active full flag: set two, release one
// (R13) Full bus bit: set two, release one
// (R14) Write queue switch may add one cycle
// (R15) Status for 32 queues, eight shown at once; the empty bus shows queues 0 to 7 only
// (R16) Mode strap low picks addressed quadrant mode
// (R17) Eight or fewer queues map straight to bits
// (R18) Strobe loads quadrant from low address bits
// (R19) Unconfigured bits in a quadrant are don't care
// (R20) Active almost-full flag is always correct
// (R21) Controller never selects queue with quadrant strobe
// (R22) Quadrant strobe needs identity match in top bits
// (R23) Mode strap high cycles quadrants every clock
module mqaf_top (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        write_en,
	input  wire logic [7:0]  write_queue_address,
	input  wire logic        write_queue_select,
	input  wire logic        read_en,
	input  wire logic [4:0]  read_queue_address,
	input  wire logic        read_queue_select,
	input  wire logic        almost_full_bus_strobe,
	input  wire logic        device_identity_bit0,
	input  wire logic        device_identity_bit1,
	input  wire logic        device_identity_bit2,
	input  wire logic        default_offset_select,
	input  wire logic        flag_bus_mode_select,
	output logic             full_flag_n,
	output logic             almost_full_flag_n,
	output logic             almost_empty_flag_n,
	output logic      [7:0]  almost_full_status_bus_n,
	output logic             almost_full_status_bus_oe_n,
	output logic      [7:0]  almost_empty_status_bus_n
);

	localparam int NQ = mqaf_pkg::NUM_QUEUES;
	localparam int QW = mqaf_pkg::QADDR_W;
	localparam int BB = mqaf_pkg::BUS_BITS;

	// ==========================================================
	// Boundary in 9-bit units
	function automatic mqaf_pkg::mqaf_cnt_t boundary(
		input mqaf_pkg::mqaf_ofs_t depth,
		input mqaf_pkg::mqaf_ofs_t ofs,
		input logic                iw,
		input logic                ow,
		input logic                both,
		input logic                full_side
	);
		mqaf_pkg::mqaf_cnt_t base;
		mqaf_pkg::mqaf_cnt_t sum;
		logic                eq;
		logic                ext;
		eq   = (iw == ow);
		base = full_side ? mqaf_pkg::mqaf_cnt_t'(depth) - mqaf_pkg::mqaf_cnt_t'(ofs)
		                 : mqaf_pkg::mqaf_cnt_t'(ofs) + mqaf_pkg::mqaf_cnt_t'(1'h1);
		// Except with wide in and narrow out, the parked output word counts when both ports shared it; full side with narrow in, wide out counts it always
		ext  = full_side ? ((eq && both) || (!iw && ow)) : ((eq || (!iw && ow)) && both);
		sum  = base + mqaf_pkg::mqaf_cnt_t'(ext);
		boundary = (iw || ow) ? {sum[mqaf_pkg::CNT_W-2:0], 1'b0} : sum;
	endfunction : boundary

	// ==========================================================
	// Pin synchronisers and straps
	logic [4:0]                       sync1_q;
	logic [4:0]                       sync2_q;
	logic [1:0]                       settle_q;
	logic                             ready_q;
	logic                             fm_q;
	logic                             df_q;

	wire logic [4:0] pins_w = {flag_bus_mode_select, default_offset_select,
	                           device_identity_bit2, device_identity_bit1,
	                           device_identity_bit0};
	wire logic       capture_w = !ready_q && (settle_q == mqaf_pkg::STRAP_SETTLE);
	wire mqaf_pkg::mqaf_ofs_t dflt_ofs_w = sync2_q[3] ? mqaf_pkg::OFS_LARGE
	                                                  : mqaf_pkg::OFS_SMALL;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q  <= 5'h00;
			sync2_q  <= 5'h00;
			settle_q <= 2'h0;
			ready_q  <= 1'b0;
			fm_q     <= 1'b0;
			df_q     <= 1'b0;
		end else begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
			if (!ready_q) begin
				settle_q <= settle_q + 2'h1;
			end
			// Straps are taken once the synchroniser holds the pin level
			if (capture_w) begin
				ready_q <= 1'b1;
				fm_q    <= sync2_q[4];
				df_q    <= sync2_q[3];
			end
		end
	end

	// ==========================================================
	// Registers
	logic [mqaf_pkg::CTRL_NQ_W-1:0]   nq_q;
	logic [1:0]                       bw_q;
	mqaf_pkg::mqaf_ofs_t              ae_ofs_q;
	mqaf_pkg::mqaf_ofs_t              af_ofs_q;
	mqaf_pkg::mqaf_ofs_t              depth_q;

	wire logic iw_w = bw_q[mqaf_pkg::CTRL_IN_WIDE];
	wire logic ow_w = bw_q[mqaf_pkg::CTRL_OUT_WIDE];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nq_q     <= mqaf_pkg::CTRL_NQ_RST;
			bw_q     <= mqaf_pkg::CTRL_BW_RST;
			ae_ofs_q <= mqaf_pkg::OFS_SMALL;
			af_ofs_q <= mqaf_pkg::OFS_SMALL;
			depth_q  <= mqaf_pkg::DEPTH_RST;
		end else begin
			if (reg_wr && reg_addr == mqaf_pkg::REG_CTRL) begin
				bw_q <= reg_wdata[mqaf_pkg::CTRL_OUT_WIDE:mqaf_pkg::CTRL_IN_WIDE];
				nq_q <= reg_wdata[mqaf_pkg::CTRL_NQ_LSB +: mqaf_pkg::CTRL_NQ_W];
			end
			if (capture_w) begin
				ae_ofs_q <= dflt_ofs_w; // [R4]
				af_ofs_q <= dflt_ofs_w; // [R11]
			end else begin
				if (reg_wr && reg_addr == mqaf_pkg::REG_AE_OFS) begin
					ae_ofs_q <= reg_wdata[mqaf_pkg::OFS_W-1:0];
				end
				if (reg_wr && reg_addr == mqaf_pkg::REG_AF_OFS) begin
					af_ofs_q <= reg_wdata[mqaf_pkg::OFS_W-1:0];
				end
			end
			if (reg_wr && reg_addr == mqaf_pkg::REG_DEPTH) begin
				depth_q <= reg_wdata[mqaf_pkg::OFS_W-1:0];
			end
		end
	end

	// ==========================================================
	// Queue selection and counters
	logic [QW-1:0]                    wq_q;
	logic [QW-1:0]                    rq_q;
	logic [NQ-1:0][mqaf_pkg::CNT_W-1:0] count_w;
	logic [NQ-1:0]                    shared_w;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wq_q <= '0;
			rq_q <= '0;
		end else begin
			if (write_queue_select) begin
				wq_q <= write_queue_address[QW-1:0];
			end
			if (read_queue_select) begin
				rq_q <= read_queue_address;
			end
		end
	end

	mqaf_qbank #(
		.NQ (NQ),
		.QW (QW),
		.CW (mqaf_pkg::CNT_W)
	) u_bank (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.wr_en    (write_en),
		.wr_q     (wq_q),
		.wr_wt    (iw_w ? 2'h2 : 2'h1),
		.rd_en    (read_en),
		.rd_q     (rq_q),
		.rd_wt    (ow_w ? 2'h2 : 2'h1),
		.count_q  (count_w),
		.shared_q (shared_w)
	);

	// ==========================================================
	// Per-queue boundaries; high means inactive
	logic [NQ-1:0] ae_raw;
	logic [NQ-1:0] af_raw;
	logic [NQ-1:0] ff_raw;
	logic [NQ-1:0] ae_nxt;
	logic [NQ-1:0] af_nxt;

	for (genvar g = 0; g < NQ; g++) begin : g_thr
		// Empty side boundary per width setting [R1] [R2] [R3]
		assign ae_raw[g] = count_w[g] >= boundary(depth_q, ae_ofs_q, iw_w, ow_w,
		                                          shared_w[g], 1'b0);
		// Full side boundary per width setting [R8] [R9] [R10]
		assign af_raw[g] = count_w[g] <  boundary(depth_q, af_ofs_q, iw_w, ow_w,
		                                          shared_w[g], 1'b1);
		assign ff_raw[g] = count_w[g] <  boundary(depth_q, 16'h0000, iw_w, ow_w,
		                                          shared_w[g], 1'b1);
	end

	// Skew margins hold on one clock, so the added cycle never occurs [R5] [R6]
	mqaf_flagpipe #(
		.N   (NQ),
		.RST (1'b0)
	) u_ae_pipe (
		.mclk   (mclk),
		.arst_n (arst_n),
		.raw    (ae_raw),
		.nxt    (ae_nxt)
	);

	mqaf_flagpipe #(
		.N   (NQ),
		.RST (1'b1)
	) u_af_pipe (
		.mclk   (mclk),
		.arst_n (arst_n),
		.raw    (af_raw),
		.nxt    (af_nxt)
	); // [R12] [R13]

	// ==========================================================
	// Status bus sharing
	mqaf_pkg::mqaf_bus_e              mode_q;
	mqaf_pkg::mqaf_bus_e              mode_d;
	logic [1:0]                       quad_q;
	logic [1:0]                       quad_d;
	logic                             own_q;
	logic                             own_d;

	wire logic [2:0] my_id_w  = sync2_q[2:0];
	// A strobe beside a queue selection is ignored; the controller avoids it [R21]
	wire logic       qstb_w   = almost_full_bus_strobe && !write_queue_select;
	wire logic       idhit_w  = write_queue_address[7:5] == my_id_w; // [R22]
	wire logic [BB-1:0] quad_bits_w = af_nxt[quad_d*BB +: BB];

	always_comb begin
		if (nq_q <= mqaf_pkg::SMALL_NQ) begin
			mode_d = mqaf_pkg::BUS_SMALL; // [R17]
		end else if (fm_q) begin
			mode_d = mqaf_pkg::BUS_POLLED;
		end else begin
			mode_d = mqaf_pkg::BUS_DIRECT; // [R16]
		end
	end

	always_comb begin
		quad_d = quad_q;
		own_d  = 1'b1;
		unique case (mode_q)
			mqaf_pkg::BUS_SMALL: begin
				quad_d = 2'h0;
			end
			mqaf_pkg::BUS_DIRECT: begin
				own_d = own_q;
				if (qstb_w) begin
					own_d = idhit_w; // [R22]
					if (idhit_w) begin
						quad_d = write_queue_address[1:0]; // [R18]
					end
				end
			end
			mqaf_pkg::BUS_POLLED: begin
				quad_d = quad_q + 2'h1; // [R23]
			end
			default: begin
				quad_d = 2'h0;
			end
		endcase
	end

	// ==========================================================
	// Output registers
	logic                             ff_q;
	logic                             af_q;
	logic                             ae_q;
	logic [BB-1:0]                    afbus_q;
	logic                             oe_n_q;
	logic [BB-1:0]                    aebus_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q  <= mqaf_pkg::BUS_SMALL;
			quad_q  <= 2'h0;
			own_q   <= 1'b1;
			ff_q    <= 1'b1;
			af_q    <= 1'b1;
			ae_q    <= 1'b0;
			afbus_q <= {BB{1'b1}};
			oe_n_q  <= 1'b0;
			aebus_q <= {BB{1'b0}};
		end else begin
			mode_q <= mode_d;
			quad_q <= quad_d;
			own_q  <= own_d;
			ff_q   <= ff_raw[wq_q];
			// Taken per queue, so a quadrant switch never disturbs it [R15] [R20]
			af_q   <= af_nxt[wq_q];
			// No extra delay is taken on a queue switch [R7] [R14]
			ae_q   <= ae_nxt[rq_q];
			// Unconfigured queues in a quadrant drive don't-care levels [R19]
			afbus_q <= quad_bits_w; // [R15]
			oe_n_q  <= !own_d;
			aebus_q <= ae_nxt[BB-1:0]; // [R6]
		end
	end

	// ==========================================================
	// Register read port
	logic [31:0] rd_mux_w;
	always_comb begin
		rd_mux_w = 32'h0000_0000;
		unique case (reg_addr)
			mqaf_pkg::REG_CTRL: begin
				rd_mux_w[mqaf_pkg::CTRL_OUT_WIDE:mqaf_pkg::CTRL_IN_WIDE] = bw_q;
				rd_mux_w[mqaf_pkg::CTRL_NQ_LSB +: mqaf_pkg::CTRL_NQ_W] = nq_q;
			end
			mqaf_pkg::REG_AE_OFS: rd_mux_w[mqaf_pkg::OFS_W-1:0] = ae_ofs_q;
			mqaf_pkg::REG_AF_OFS: rd_mux_w[mqaf_pkg::OFS_W-1:0] = af_ofs_q;
			mqaf_pkg::REG_DEPTH:  rd_mux_w[mqaf_pkg::OFS_W-1:0] = depth_q;
			mqaf_pkg::REG_STATUS: begin
				rd_mux_w[mqaf_pkg::STAT_QUAD_LSB +: 2] = quad_q;
				rd_mux_w[mqaf_pkg::STAT_OWN]   = own_q;
				rd_mux_w[mqaf_pkg::STAT_FM]    = fm_q;
				rd_mux_w[mqaf_pkg::STAT_DF]    = df_q;
				rd_mux_w[mqaf_pkg::STAT_READY] = ready_q;
			end
			mqaf_pkg::REG_WCOUNT: rd_mux_w[mqaf_pkg::CNT_W-1:0] = count_w[wq_q];
			default: rd_mux_w = 32'h0000_0000;
		endcase
	end

	logic [31:0] rdata_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= reg_rd ? rd_mux_w : 32'h0000_0000;
		end
	end

	assign reg_rdata                   = rdata_r;
	assign full_flag_n                 = ff_q;
	assign almost_full_flag_n          = af_q;
	assign almost_empty_flag_n         = ae_q;
	assign almost_full_status_bus_n    = afbus_q;
	assign almost_full_status_bus_oe_n = oe_n_q;
	assign almost_empty_status_bus_n   = aebus_q;

	// ==========================================================
	// Checks
	wire logic act_af_w = af_raw[wq_q];
	wire logic act_ae_w = ae_raw[rq_q];

	af_set_delay_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R12]
		(!act_af_w && $past(!act_af_w) && $stable(wq_q)) |=> !almost_full_flag_n)
		else $error("almost full flag missed its two-cycle assertion");
	af_release_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R12]
		act_af_w |=> almost_full_flag_n)
		else $error("almost full flag late to release");
	ae_set_delay_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R5]
		($fell(act_ae_w) && $stable(rq_q)) ##1 (!act_ae_w && $stable(rq_q))
		|-> almost_empty_flag_n ##1 !almost_empty_flag_n)
		else $error("almost empty flag not asserted on the second cycle");
	ae_release_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R5]
		act_ae_w |=> almost_empty_flag_n)
		else $error("almost empty flag late to release");
	quad_load_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R18]
		(mode_q == mqaf_pkg::BUS_DIRECT && qstb_w && idhit_w)
		|=> quad_q == $past(write_queue_address[1:0]))
		else $error("quadrant not loaded from the address");
	quad_other_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R22]
		(mode_q == mqaf_pkg::BUS_DIRECT && qstb_w && !idhit_w)
		|=> almost_full_status_bus_oe_n && $stable(quad_q))
		else $error("foreign identity took the status bus");
	poll_step_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R23]
		mode_q == mqaf_pkg::BUS_POLLED |=> quad_q == $past(quad_q) + 2'h1)
		else $error("polled quadrant did not advance");
	small_map_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R17]
		mode_q == mqaf_pkg::BUS_SMALL |=> almost_full_status_bus_n == $past(af_nxt[BB-1:0]))
		else $error("small setup bus bits not mapped straight");
	strap_dflt_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R4]
		capture_w |=> ae_ofs_q == (df_q ? mqaf_pkg::OFS_LARGE : mqaf_pkg::OFS_SMALL)
		           && af_ofs_q == ae_ofs_q)
		else $error("default offset not taken from the strap");

endmodule : mqaf_top

// ==== test/mqaf_ctl_model.sv ====
// Purpose: Behavioural queue controller driving both ports of the flag logic
// Assumes: Called from one bench process; every change lands by NBA after a rising edge
// Notes:   Queue selects and quadrant strobes share a cycle only when a call asks for it
module mqaf_ctl_model (
	input  wire logic       mclk,
	output logic            write_en,
	output logic      [7:0] write_queue_address,
	output logic            write_queue_select,
	output logic            read_en,
	output logic      [4:0] read_queue_address,
	output logic            read_queue_select,
	output logic            almost_full_bus_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle levels
	initial begin
		write_en               = 1'b0;
		write_queue_address    = 8'h00;
		write_queue_select     = 1'b0;
		read_en                = 1'b0;
		read_queue_address     = 5'h00;
		read_queue_select      = 1'b0;
		almost_full_bus_strobe = 1'b0;
	end

	// ==========================================================
	// Port operations
	task automatic sel_w(input logic [4:0] q);
		@(posedge mclk);
		write_queue_address <= {3'h0, q};
		write_queue_select  <= 1'b1;
		@(posedge mclk);
		write_queue_select  <= 1'b0;
	endtask : sel_w

	task automatic sel_r(input logic [4:0] q);
		@(posedge mclk);
		read_queue_address <= q;
		read_queue_select  <= 1'b1;
		@(posedge mclk);
		read_queue_select  <= 1'b0;
	endtask : sel_r

	// Back-to-back words; the last one is taken at the edge that lowers the enable
	task automatic wr(input int k);
		repeat (k) begin
			@(posedge mclk);
			write_en <= 1'b1;
		end
		@(posedge mclk);
		write_en <= 1'b0;
	endtask : wr

	task automatic rd(input int k);
		repeat (k) begin
			@(posedge mclk);
			read_en <= 1'b1;
		end
		@(posedge mclk);
		read_en <= 1'b0;
	endtask : rd

	// Top three address bits carry the target identity, low two the quadrant
	task automatic strobe(input logic [7:0] a, input logic ws);
		@(posedge mclk);
		write_queue_address    <= a;
		almost_full_bus_strobe <= 1'b1;
		write_queue_select     <= ws;
		@(posedge mclk);
		almost_full_bus_strobe <= 1'b0;
		write_queue_select     <= 1'b0;
	endtask : strobe

endmodule : mqaf_ctl_model

// ==== test/mqaf_top_tb.sv ====
// Purpose: Self-checking bench for the multi-queue almost flag logic
// Assumes: Identity pins at zero until the identity scenario; straps set before each reset
// Notes:   Fresh queues per boundary so earlier traffic never shifts a count
module mqaf_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, arst_n, reg_wr, reg_rd, df_sel, fm_sel;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        write_en, write_queue_select, read_en, read_queue_select, strobe;
	logic [7:0]  write_queue_address, af_bus_n, ae_bus_n;
	logic [4:0]  read_queue_address;
	logic        full_flag_n, af_flag_n, ae_flag_n, oe_n;
	logic [2:0]  id_sel;
	int          n_errors, cmp_count;
	logic [31:0] s1, s2;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	mqaf_ctl_model u_ctl (.mclk(mclk), .write_en(write_en),
		.write_queue_address(write_queue_address), .write_queue_select(write_queue_select),
		.read_en(read_en), .read_queue_address(read_queue_address),
		.read_queue_select(read_queue_select), .almost_full_bus_strobe(strobe));

	mqaf_top u_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.write_en(write_en), .write_queue_address(write_queue_address),
		.write_queue_select(write_queue_select), .read_en(read_en),
		.read_queue_address(read_queue_address), .read_queue_select(read_queue_select),
		.almost_full_bus_strobe(strobe), .device_identity_bit0(id_sel[0]),
		.device_identity_bit1(id_sel[1]), .device_identity_bit2(id_sel[2]),
		.default_offset_select(df_sel), .flag_bus_mode_select(fm_sel),
		.full_flag_n(full_flag_n), .almost_full_flag_n(af_flag_n),
		.almost_empty_flag_n(ae_flag_n), .almost_full_status_bus_n(af_bus_n),
		.almost_full_status_bus_oe_n(oe_n), .almost_empty_status_bus_n(ae_bus_n));

	// ==========================================================
	// Helpers
	task automatic wrap_up;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset(input logic df, input logic fm);
		@(posedge mclk);
		arst_n <= 1'b0;
		df_sel <= df;
		fm_sel <= fm;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		// Straps are captured a few edges after release
		repeat (6) @(posedge mclk);
	endtask : do_reset

	task automatic rw(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : rw

	task automatic rr(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : rr

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rr(a, d);
		chk(d, exp);
	endtask : rc

	// Empty side watched on its bus bit, full side on the active flag
	function automatic logic look(input bit af, input int q);
		look = af ? af_flag_n : ae_bus_n[q[2:0]];
	endfunction : look

	// k-1 words leave the flag as it was; the k-th flips it, release one edge, set two
	task automatic bound(input bit af, input int q, input int k, input bit shared);
		u_ctl.sel_w(q[4:0]);
		u_ctl.sel_r(shared ? q[4:0] : 5'h1F);
		u_ctl.wr(k - 1);
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, look(af, q)}, {31'h0, af});
		u_ctl.wr(1);
		@(posedge mclk);
		#1 chk({31'h0, look(af, q)}, 32'h1);
		@(posedge mclk);
		#1 chk({31'h0, look(af, q)}, {31'h0, !af});
	endtask : bound

	// ==========================================================
	// Sequence
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		wrap_up();
	end

	initial begin
		n_errors = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		df_sel = 1'b0;
		fm_sel = 1'b0;
		id_sel = 3'h0;
		do_reset(1'b0, 1'b0);
		rc(mqaf_pkg::REG_CTRL, 32'h0000_2000);
		rc(mqaf_pkg::REG_AE_OFS, 32'h0000_0008);
		rc(mqaf_pkg::REG_AF_OFS, 32'h0000_0008);
		rc(mqaf_pkg::REG_DEPTH, 32'h0000_0800);
		rw(mqaf_pkg::REG_STATUS, 32'hFFFF_FFFF);
		rc(mqaf_pkg::REG_STATUS, 32'h0000_0024);
		rw(8'h18, 32'h0000_00FF);
		rc(8'h18, 32'h0);
		rw(mqaf_pkg::REG_DEPTH, 32'h0000_0020);
		bound(0, 0, 10, 1);
		u_ctl.rd(1);
		@(posedge mclk);
		#1 chk({31'h0, ae_flag_n}, 32'h1);
		@(posedge mclk);
		#1 chk({31'h0, ae_flag_n}, 32'h0);
		chk({24'h0, ae_bus_n}, 32'h0000_0000);
		bound(0, 1, 9, 0);
		rw(mqaf_pkg::REG_CTRL, 32'h0000_2001);
		bound(0, 2, 9, 0);
		bound(1, 10, 24, 0);
		rw(mqaf_pkg::REG_CTRL, 32'h0000_2002);
		bound(0, 3, 20, 1);
		bound(0, 4, 18, 0);
		bound(1, 11, 50, 0);
		rw(mqaf_pkg::REG_CTRL, 32'h0000_2000);
		bound(1, 8, 24, 0);
		u_ctl.wr(8);
		repeat (2) @(posedge mclk);
		#1 chk({31'h0, full_flag_n}, 32'h0);
		bound(1, 9, 25, 1);
		for (int i = 0; i < 4; i++) begin
			u_ctl.strobe({6'h00, i[1:0]}, 1'b0);
			#1 chk({23'h0, oe_n, af_bus_n}, (i == 1) ? 32'h0000_00F0 : 32'h0000_00FF);
		end
		u_ctl.strobe(8'h20, 1'b0);
		#1 chk({31'h0, oe_n}, 32'h1);
		rc(mqaf_pkg::REG_STATUS, 32'h0000_0023);
		u_ctl.strobe(8'h01, 1'b1);
		rc(mqaf_pkg::REG_STATUS, 32'h0000_0023);
		// Identity pins pass a two-stage synchroniser before the match uses them
		@(posedge mclk);
		id_sel <= 3'h5;
		repeat (3) @(posedge mclk);
		u_ctl.strobe(8'hA2, 1'b0);
		#1 chk({23'h0, oe_n, af_bus_n}, 32'h0000_00FF);
		rc(mqaf_pkg::REG_STATUS, 32'h0000_0026);
		do_reset(1'b1, 1'b1);
		rc(mqaf_pkg::REG_AE_OFS, 32'h0000_0080);
		rc(mqaf_pkg::REG_AF_OFS, 32'h0000_0080);
		rr(mqaf_pkg::REG_STATUS, s1);
		rr(mqaf_pkg::REG_STATUS, s2);
		chk({30'h0, s2[1:0] - s1[1:0]}, 32'h2);
		rw(mqaf_pkg::REG_CTRL, 32'h0000_0800);
		// Mode follows the write one edge late, so one more poll step can land
		@(posedge mclk);
		rr(mqaf_pkg::REG_STATUS, s1);
		rr(mqaf_pkg::REG_STATUS, s2);
		chk({28'h0, s1[1:0], s2[1:0]}, 32'h0);
		wrap_up();
	end

endmodule : mqaf_top_tb
